// ==== hw/dor_params.svh ====
// Constants of the digital output routing block: offsets, fields, resets, timing
`ifndef DOR_PARAMS_SVH
`define DOR_PARAMS_SVH

`define DOR_OFS_SRC_LO      32'h0000_0000
`define DOR_OFS_SRC_HI      32'h0000_0004
`define DOR_OFS_INV         32'h0000_0008
`define DOR_OFS_CFG         32'h0000_000c
`define DOR_OFS_HOST        32'h0000_0010
`define DOR_OFS_STATUS      32'h0000_0014
`define DOR_OFS_SNAP        32'h0000_0018
`define DOR_OFS_AOUT        32'h0000_001c
`define DOR_OFS_IRQ_STAT    32'h0000_0020
`define DOR_OFS_IRQ_EN      32'h0000_0024
`define DOR_OFS_IRQ_CLR     32'h0000_0028

// CFG fields
`define DOR_CFG_INCPL_LSB   0
`define DOR_CFG_MODCFG_LSB  4
`define DOR_CFG_SERMODE_LSB 8
`define DOR_CFG_CTYPE_LSB   12
`define DOR_CFG_AOSRC_LSB   16
`define DOR_CFG_AOLIVE_BIT  20
`define DOR_CFG_TRKPRI_BIT  21

`define DOR_SRC_RESET       32'h0000_0000
`define DOR_INV_RESET       8'h00
`define DOR_CFG_RESET       32'h0000_0000

`define DOR_SERMODE_HOST    3'h2
`define DOR_CTYPE_CTRLUNIT  3'h4
`define DOR_MOD_NONE        2'h0
`define DOR_MOD_FOUR        2'h1
`define DOR_MOD_RELAY       2'h3

`define DOR_CYCLE_MS        20
`define DOR_CLK_KHZ         100000
`define DOR_CYCLE_CLKS      (`DOR_CYCLE_MS * `DOR_CLK_KHZ)

`define DOR_AO_FULL         12'hfff
`define DOR_AO_LIVE_ZERO    12'h333
`define DOR_AO_HALF         12'h800

`endif

// ==== hw/dor_pkg.sv ====
// Types of the digital output routing block
package dor_pkg;

    typedef struct packed {
        logic front_manual_select;
        logic external_manual_input;
        logic safety_input;
        logic direction_block_up;
        logic direction_block_down;
        logic tracking_input;
        logic internal_setpoint_sel;
        logic computer_standby_input;
        logic [3:0] limit_alarm;
        logic [3:0] range_exceeded;
        logic setpoint_inc;
        logic setpoint_dec;
        logic position_inc;
        logic position_dec;
    } dor_ctrl_in_t;

    typedef struct packed {
        logic [11:0] control_difference;
        logic [11:0] actual_value;
        logic [11:0] setpoint;
        logic [11:0] manipulated;
    } dor_analog_in_t;

    typedef enum logic [2:0] {
        DOR_SRC_NONE = 3'h0,
        DOR_SRC_SB = 3'h1,
        DOR_SRC_OP = 3'h2,
        DOR_SRC_MAN = 3'h3,
        DOR_SRC_TRK = 3'h4,
        DOR_SRC_AL12 = 3'h5,
        DOR_SRC_AL34 = 3'h6,
        DOR_SRC_MUF = 3'h7
    } dor_src_t;

    typedef enum logic [1:0] {
        DOR_PL_NONE = 2'h0,
        DOR_PL_12 = 2'h1,
        DOR_PL_78 = 2'h2,
        DOR_PL_RSV = 2'h3
    } dor_place_t;

    typedef enum logic [2:0] {
        DOR_BUS_IDLE = 3'b001,
        DOR_BUS_WRESP = 3'b010,
        DOR_BUS_RDATA = 3'b100
    } dor_bus_state_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
        dor_bus_state_t wst;
        dor_bus_state_t rst;
    } dor_bus_t;

    typedef struct packed {
        dor_bus_t bus;
        logic [63:0] src_sel;
        logic [7:0] invert;
        logic [31:0] cfg;
        logic [7:0] host_out;
        logic [7:0] dout;
        logic [7:0] snap;
        logic [11:0] aout;
        logic [7:0] msgs;
        logic mod_err;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic irq;
        logic [31:0] cyc_cnt;
    } dor_state_t;

endpackage : dor_pkg

// ==== hw/dor_top.sv ====
// Digital output routing with AXI4-Lite register access
`include "dor_params.svh"

module dor_top #(
    parameter int unsigned CYCLE_CLKS = `DOR_CYCLE_CLKS,
    parameter int unsigned NUM_OUT = 8,
    parameter int unsigned SEL_W = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    input wire dor_pkg::dor_ctrl_in_t CTRL_IN,
    input wire dor_pkg::dor_analog_in_t ANALOG_IN,
    input wire logic [1:0] FITTED_MODULE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [7:0] DIGITAL_OUT,
    output logic [7:0] OUT_ENABLE,
    output logic [11:0] ANALOG_OUT,
    output logic MODULE_ERROR,
    output logic IRQ
);
    import dor_pkg::*;

    dor_state_t s_q;
    dor_state_t s_d;

    // Merge written bytes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Output enables implied by fitted module
    function automatic logic [7:0] mod_enables(input logic [1:0] m);
        logic [7:0] e;
        e = 8'hc3;
        if (m == `DOR_MOD_FOUR) begin
            e = 8'hff;
        end else if (m == `DOR_MOD_RELAY) begin
            e = 8'hcf;
        end
        return e;
    endfunction : mod_enables

    logic [1:0] incpl;
    logic [1:0] modcfg;
    logic [2:0] sermode;
    logic [2:0] ctype;
    logic [2:0] aosrc;
    logic ao_live;
    logic trk_pri;
    logic tick;
    logic manual_req;
    logic blocked;
    logic [7:0] src_msgs;
    logic [7:0] combined;
    logic [7:0] routed;
    logic [7:0] inc_mask;
    logic [7:0] inc_val;
    logic [7:0] unassigned;
    logic [11:0] ao_raw;
    logic [23:0] ao_prod;
    logic [11:0] ao_scaled;
    logic [2:0] irq_evt;

    // Configuration fields
    assign incpl = s_q.cfg[`DOR_CFG_INCPL_LSB +: 2];
    assign modcfg = s_q.cfg[`DOR_CFG_MODCFG_LSB +: 2];
    assign sermode = s_q.cfg[`DOR_CFG_SERMODE_LSB +: 3];
    assign ctype = s_q.cfg[`DOR_CFG_CTYPE_LSB +: 3];
    assign aosrc = s_q.cfg[`DOR_CFG_AOSRC_LSB +: 3];
    assign ao_live = s_q.cfg[`DOR_CFG_AOLIVE_BIT];
    assign trk_pri = s_q.cfg[`DOR_CFG_TRKPRI_BIT];
    assign tick = (s_q.cyc_cnt >= 32'(CYCLE_CLKS - 1));

    // Message signal generation
    always_comb begin
        blocked = CTRL_IN.safety_input | CTRL_IN.direction_block_up | CTRL_IN.direction_block_down;
        manual_req = CTRL_IN.front_manual_select | CTRL_IN.external_manual_input;
        src_msgs = '0;
        src_msgs[DOR_SRC_SB] = ~CTRL_IN.computer_standby_input;
        src_msgs[DOR_SRC_OP] = ~(CTRL_IN.internal_setpoint_sel & CTRL_IN.computer_standby_input);
        src_msgs[DOR_SRC_MAN] = manual_req & ~blocked & ~(trk_pri & CTRL_IN.tracking_input);
        src_msgs[DOR_SRC_TRK] = CTRL_IN.tracking_input & ~blocked & ~(~trk_pri & manual_req);
        src_msgs[DOR_SRC_AL12] = CTRL_IN.limit_alarm[0] | CTRL_IN.limit_alarm[1];
        src_msgs[DOR_SRC_AL34] = CTRL_IN.limit_alarm[2] | CTRL_IN.limit_alarm[3];
        src_msgs[DOR_SRC_MUF] = |CTRL_IN.range_exceeded;
    end

    // Per-output combine, invert, host fallback
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        logic [SEL_W-1:0] sel;
        logic sp_inc;
        logic sp_dec;
        assign sel = s_q.src_sel[i*SEL_W +: SEL_W];
        assign sp_inc = sel[0] & CTRL_IN.setpoint_inc & (ctype == `DOR_CTYPE_CTRLUNIT);
        assign sp_dec = sel[0] & CTRL_IN.setpoint_dec & (ctype == `DOR_CTYPE_CTRLUNIT);
        assign combined[i] = |(sel[7:1] & src_msgs[7:1]);
        assign unassigned[i] = (sel == '0);
        // Inversion after OR, increments bypass it
        assign routed[i] = unassigned[i] ? ((sermode == `DOR_SERMODE_HOST) & s_q.host_out[i])
                         : ((combined[i] ^ (s_q.invert[i] & (|sel[7:1]))) | sp_inc | sp_dec);
    end

    // Positioning increment placement
    always_comb begin
        inc_mask = 8'h00;
        inc_val = 8'h00;
        unique case (incpl)
            DOR_PL_12: begin
                inc_mask = 8'h03;
                inc_val = {6'h00, CTRL_IN.position_dec, CTRL_IN.position_inc};
            end
            DOR_PL_78: begin
                inc_mask = 8'hc0;
                inc_val = {CTRL_IN.position_dec, CTRL_IN.position_inc, 6'h00};
            end
            default: begin
                inc_mask = 8'h00;
                inc_val = 8'h00;
            end
        endcase
    end

    // Analog output source and range
    always_comb begin
        unique case (aosrc)
            3'h0: ao_raw = ANALOG_IN.control_difference + `DOR_AO_HALF;
            3'h1: ao_raw = ANALOG_IN.actual_value;
            3'h2: ao_raw = ANALOG_IN.setpoint;
            default: ao_raw = ANALOG_IN.manipulated;
        endcase
        ao_prod = 24'(ao_raw) * 24'(`DOR_AO_FULL - `DOR_AO_LIVE_ZERO + 12'h1); // Top input reaches top code
        ao_scaled = ao_live ? 12'(`DOR_AO_LIVE_ZERO + 12'(ao_prod >> 12)) : ao_raw;
    end

    // Register next state and bus slave
    always_comb begin
        s_d = s_q;
        irq_evt = 3'h0;
        if (s_q.cyc_cnt >= 32'(CYCLE_CLKS - 1)) begin
            s_d.cyc_cnt = '0;
        end else begin
            s_d.cyc_cnt = s_q.cyc_cnt + 32'h1;
        end
        if (tick) begin
            // Increment placement wins over general routing
            s_d.dout = ((routed & ~inc_mask) | (inc_val & inc_mask)) & mod_enables(FITTED_MODULE);
            s_d.snap = routed & ~inc_mask & mod_enables(FITTED_MODULE);
            s_d.aout = ao_scaled;
            s_d.msgs = src_msgs;
            irq_evt[0] = 1'b1;
            irq_evt[1] = (src_msgs[DOR_SRC_MUF] & ~s_q.msgs[DOR_SRC_MUF]);
        end
        s_d.mod_err = (modcfg != FITTED_MODULE);
        irq_evt[2] = s_d.mod_err & ~s_q.mod_err;
        // Write channel capture
        if (S_AXI_AWVALID & ~s_q.bus.aw_have & (s_q.bus.wst == DOR_BUS_IDLE)) begin
            s_d.bus.awaddr = S_AXI_AWADDR;
            s_d.bus.aw_have = 1'b1;
        end
        if (S_AXI_WVALID & ~s_q.bus.w_have & (s_q.bus.wst == DOR_BUS_IDLE)) begin
            s_d.bus.wdata = S_AXI_WDATA;
            s_d.bus.wstrb = S_AXI_WSTRB;
            s_d.bus.w_have = 1'b1;
        end
        // Clear applied first so a same-cycle event still sets
        unique case (s_q.bus.wst)
            DOR_BUS_IDLE: begin
                if (s_q.bus.aw_have & s_q.bus.w_have) begin
                    s_d.bus.bresp = 2'b00;
                    unique case ({24'h0, s_q.bus.awaddr})
                        `DOR_OFS_SRC_LO: s_d.src_sel[31:0] = merge(s_q.src_sel[31:0], s_q.bus.wdata, s_q.bus.wstrb);
                        `DOR_OFS_SRC_HI: s_d.src_sel[63:32] = merge(s_q.src_sel[63:32], s_q.bus.wdata, s_q.bus.wstrb);
                        `DOR_OFS_INV: s_d.invert = 8'(merge({24'h0, s_q.invert}, s_q.bus.wdata, s_q.bus.wstrb));
                        `DOR_OFS_CFG: s_d.cfg = merge(s_q.cfg, s_q.bus.wdata, s_q.bus.wstrb);
                        `DOR_OFS_HOST: s_d.host_out = 8'(merge({24'h0, s_q.host_out}, s_q.bus.wdata, s_q.bus.wstrb));
                        `DOR_OFS_IRQ_EN: s_d.irq_en = 3'(merge({29'h0, s_q.irq_en}, s_q.bus.wdata, s_q.bus.wstrb));
                        `DOR_OFS_IRQ_CLR: begin
                            if (s_q.bus.wstrb[0]) begin
                                s_d.irq_stat = s_q.irq_stat & ~s_q.bus.wdata[2:0];
                            end
                        end
                        `DOR_OFS_STATUS, `DOR_OFS_SNAP, `DOR_OFS_AOUT, `DOR_OFS_IRQ_STAT: s_d.bus.bresp = 2'b00;
                        default: s_d.bus.bresp = 2'b10;
                    endcase
                    s_d.bus.aw_have = 1'b0;
                    s_d.bus.w_have = 1'b0;
                    s_d.bus.wst = DOR_BUS_WRESP;
                end
            end
            DOR_BUS_WRESP: begin
                if (S_AXI_BREADY) begin
                    s_d.bus.wst = DOR_BUS_IDLE;
                end
            end
            default: s_d.bus.wst = DOR_BUS_IDLE;
        endcase
        s_d.irq_stat = s_d.irq_stat | irq_evt;
        s_d.irq = |(s_d.irq_stat & s_d.irq_en);
        // Read channel
        unique case (s_q.bus.rst)
            DOR_BUS_IDLE: begin
                if (S_AXI_ARVALID) begin
                    s_d.bus.rresp = 2'b00;
                    unique case ({24'h0, S_AXI_ARADDR})
                        `DOR_OFS_SRC_LO: s_d.bus.rdata = s_q.src_sel[31:0];
                        `DOR_OFS_SRC_HI: s_d.bus.rdata = s_q.src_sel[63:32];
                        `DOR_OFS_INV: s_d.bus.rdata = {24'h0, s_q.invert};
                        `DOR_OFS_CFG: s_d.bus.rdata = s_q.cfg;
                        `DOR_OFS_HOST: s_d.bus.rdata = {24'h0, s_q.host_out};
                        `DOR_OFS_STATUS: s_d.bus.rdata = {15'h0, s_q.mod_err, s_q.msgs, s_q.dout};
                        `DOR_OFS_SNAP: s_d.bus.rdata = {24'h0, s_q.snap};
                        `DOR_OFS_AOUT: s_d.bus.rdata = {20'h0, s_q.aout};
                        `DOR_OFS_IRQ_STAT: s_d.bus.rdata = {29'h0, s_q.irq_stat};
                        `DOR_OFS_IRQ_EN: s_d.bus.rdata = {29'h0, s_q.irq_en};
                        `DOR_OFS_IRQ_CLR: s_d.bus.rdata = 32'h0;
                        default: begin
                            s_d.bus.rdata = 32'h0;
                            s_d.bus.rresp = 2'b10;
                        end
                    endcase
                    s_d.bus.rst = DOR_BUS_RDATA;
                end
            end
            DOR_BUS_RDATA: begin
                if (S_AXI_RREADY) begin
                    s_d.bus.rst = DOR_BUS_IDLE;
                end
            end
            default: s_d.bus.rst = DOR_BUS_IDLE;
        endcase
    end

    // State register with clock enable and sync reset
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            s_q <= '0;
            s_q.bus.wst <= DOR_BUS_IDLE;
            s_q.bus.rst <= DOR_BUS_IDLE;
            s_q.src_sel <= 64'(`DOR_SRC_RESET);
            s_q.invert <= `DOR_INV_RESET;
            s_q.cfg <= `DOR_CFG_RESET;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    // Ports straight from state, except OUT_ENABLE decoded from FITTED_MODULE
    assign S_AXI_AWREADY = ~s_q.bus.aw_have & (s_q.bus.wst == DOR_BUS_IDLE);
    assign S_AXI_WREADY = ~s_q.bus.w_have & (s_q.bus.wst == DOR_BUS_IDLE);
    assign S_AXI_BVALID = (s_q.bus.wst == DOR_BUS_WRESP);
    assign S_AXI_BRESP = s_q.bus.bresp;
    assign S_AXI_ARREADY = (s_q.bus.rst == DOR_BUS_IDLE);
    assign S_AXI_RVALID = (s_q.bus.rst == DOR_BUS_RDATA);
    assign S_AXI_RDATA = s_q.bus.rdata;
    assign S_AXI_RRESP = s_q.bus.rresp;
    assign DIGITAL_OUT = s_q.dout;
    assign OUT_ENABLE = mod_enables(FITTED_MODULE);
    assign ANALOG_OUT = s_q.aout;
    assign MODULE_ERROR = s_q.mod_err;
    assign IRQ = s_q.irq;

endmodule : dor_top

// ==== verif/dor_properties.sv ====
// Checker of bus timing, output refresh and enable mapping
module dor_properties #(
    parameter int unsigned CYCLE_CLKS = 20
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [1:0] FITTED_MODULE,
    input wire logic [7:0] OUT_ENABLE,
    input wire logic [7:0] DIGITAL_OUT,
    input wire logic [11:0] ANALOG_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    // Accepted requests
    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // Enables follow the fitted module
    property p_oe_map;
        OUT_ENABLE == (FITTED_MODULE == 2'h1 ? 8'hff : (FITTED_MODULE == 2'h3 ? 8'hcf : 8'hc3));
    endproperty
    a_oe_map: assert property (p_oe_map) else $error("Output enable mismatch");
    // Outputs hold for at least eight clocks after each move
    property p_dout_hold;
        $changed(DIGITAL_OUT) |=> $stable(DIGITAL_OUT) [*8];
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("Digital out moved early");
    property p_aout_hold;
        $changed(ANALOG_OUT) |=> $stable(ANALOG_OUT) [*8];
    endproperty
    a_aout_hold: assert property (p_aout_hold) else $error("Analog out moved early");
    // Write channel sequencing
    property p_ready_drop;
        s_wr_taken |=> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("Write readies stayed high");
    property p_b_timing;
        s_wr_taken |-> ##[1:3] S_AXI_BVALID;
    endproperty
    a_b_timing: assert property (p_b_timing) else $error("Write response late");
    property p_b_once;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
    endproperty
    a_b_once: assert property (p_b_once) else $error("Write response repeated");
    // Read channel sequencing
    property p_r_timing;
        s_rd_taken |=> S_AXI_RVALID;
    endproperty
    a_r_timing: assert property (p_r_timing) else $error("Read data late");
    property p_r_once;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_r_once: assert property (p_r_once) else $error("Read data repeated");
endmodule : dor_properties

bind dor_top dor_properties #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .FITTED_MODULE(FITTED_MODULE),
    .OUT_ENABLE(OUT_ENABLE), .DIGITAL_OUT(DIGITAL_OUT), .ANALOG_OUT(ANALOG_OUT)
);

// ==== verif/dor_field_model.sv ====
// Field side: fitted module code and enable-gated (dout AND oe) view of the outputs
module dor_field_model (
    input wire logic [1:0] fit_code,
    input wire logic [7:0] dout,
    input wire logic [7:0] oe,
    output logic [1:0] fitted,
    output logic [7:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Fitted module reports its own code
    assign fitted = fit_code;
    // Undriven lines fall low behind the diodes
    assign seen = dout & oe;
endmodule : dor_field_model

// ==== verif/dor_top_test.sv ====
// Self-checking bench of the digital output routing block
`include "dor_params.svh"
module dor_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dor_pkg::*;
    localparam int unsigned CYC = 20;
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, dout, oe, seen, inv = 8'h00, host = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, cfg = 32'h0, d;
    logic [1:0] bresp, rresp, r, fit_code = 2'h0, fitted;
    logic awready, wready, bvalid, arready, rvalid, mod_err, irq;
    logic [11:0] aout;
    logic [63:0] src = 64'h0;
    dor_ctrl_in_t ctrl = '0;
    dor_analog_in_t ana = '0;
    int mismatches = 0, tests_run = 0;
    dor_ctrl_in_t vec [6] = '{20'h00000, 20'h84000, 20'h60000, 20'h0c000, 20'h03280, 20'h80400};
    logic [7:0] oe_tab [4] = '{8'hc3, 8'hff, 8'hc3, 8'hcf};
    logic [11:0] ao_tab [4] = '{12'h800, 12'habc, 12'h123, 12'h456};

    dor_top #(.CYCLE_CLKS(CYC)) uut (
        .CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .CTRL_IN(ctrl), .ANALOG_IN(ana), .FITTED_MODULE(fitted),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .DIGITAL_OUT(dout), .OUT_ENABLE(oe), .ANALOG_OUT(aout),
        .MODULE_ERROR(mod_err), .IRQ(irq)
    );
    dor_field_model field (.fit_code(fit_code), .dout(dout), .oe(oe), .fitted(fitted), .seen(seen));

    // Free running clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic hang;
        mismatches++;
        report_and_stop();
    endtask : hang

    // Bus write: address and data offered together, response awaited
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a[7:0];
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                done = 1'b1;
                chk("write resp", 32'(er), 32'(bresp));
            end
        end
        if (!done) hang();
    endtask : wr

    // Bus read into d and r
    task automatic rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a[7:0];
        arv <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk);
            if (arv && arready) arv <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
                done = 1'b1;
            end
        end
        if (!done) hang();
    endtask : rd

    task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        rd(a);
        chk($sformatf("reg %h", a[7:0]), e, d & m);
        chk("read resp", 32'(er), 32'(r));
    endtask : rchk

    // Expected messages, bit 1 upward
    function automatic logic [7:0] msgs_of(input dor_ctrl_in_t c, input logic tp);
        logic mreq, blk;
        mreq = c.front_manual_select | c.external_manual_input;
        blk = c.safety_input | c.direction_block_up | c.direction_block_down;
        return {|c.range_exceeded, |c.limit_alarm[3:2], |c.limit_alarm[1:0],
            c.tracking_input & ~blk & ~(~tp & mreq), mreq & ~blk & ~(tp & c.tracking_input),
            ~(c.internal_setpoint_sel & c.computer_standby_input), ~c.computer_standby_input, 1'b0};
    endfunction : msgs_of

    // Expected routed outputs
    function automatic logic [7:0] exp_out();
        logic [7:0] m, e, s;
        m = msgs_of(ctrl, cfg[`DOR_CFG_TRKPRI_BIT]);
        for (int i = 0; i < 8; i++) begin
            s = src[8*i +: 8];
            e[i] = (s == 8'h00) ? (cfg[10:8] == `DOR_SERMODE_HOST && host[i]) : ((|(s & m)) ^ (inv[i] & |s[7:1]));
        end
        if (cfg[1:0] == 2'h1) e[1:0] = {ctrl.position_dec, ctrl.position_inc};
        if (cfg[1:0] == 2'h2) e[7:6] = {ctrl.position_dec, ctrl.position_inc};
        return e;
    endfunction : exp_out

    // Let two processing cycles pass, then compare outputs and snapshot
    task automatic outs(input logic [7:0] pm);
        repeat (2 * CYC + 5) @(posedge clk);
        chk("digital out", 32'(exp_out()), 32'(dout));
        chk("field view", 32'(exp_out()), 32'(seen));
        rchk(`DOR_OFS_SNAP, 32'(exp_out() & ~pm), 32'hff, 2'h0);
    endtask : outs

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rchk(`DOR_OFS_SRC_LO, 0, '1, 2'h0);
        rchk(`DOR_OFS_INV, 0, '1, 2'h0);
        rchk(`DOR_OFS_CFG, 0, '1, 2'h0);
        rchk(`DOR_OFS_IRQ_CLR, 0, '1, 2'h0);
        rchk(32'h40, 0, '1, 2'h2);
        wr(32'h40, '1, 2'h2);
        wr(`DOR_OFS_STATUS, '1, 2'h0);
        for (int k = 0; k < 4; k++) begin
            fit_code <= 2'(k);
            wr(`DOR_OFS_CFG, 32'(k ^ 1) << 4, 2'h0);
            repeat (2) @(posedge clk);
            chk("out enable", 32'(oe_tab[k]), 32'(oe));
            chk("module error", 1, 32'(mod_err));
            wr(`DOR_OFS_CFG, 32'(k) << 4, 2'h0);
            repeat (2) @(posedge clk);
            chk("module error", 0, 32'(mod_err));
        end
        fit_code <= 2'h1;
        src = 64'h6080_4020_1008_0402;
        wr(`DOR_OFS_SRC_LO, src[31:0], 2'h0);
        wr(`DOR_OFS_SRC_HI, src[63:32], 2'h0);
        for (int p = 0; p < 2; p++) begin
            inv = p ? 8'ha5 : 8'h00;
            cfg = p ? 32'h0020_0010 : 32'h0000_0010;
            wr(`DOR_OFS_INV, 32'(inv), 2'h0);
            wr(`DOR_OFS_CFG, cfg, 2'h0);
            foreach (vec[j]) begin
                ctrl <= vec[j];
                outs(8'h00);
            end
        end
        src[63:32] = 32'h0;
        inv = 8'h00;
        host = 8'h5a;
        wr(`DOR_OFS_INV, 0, 2'h0);
        wr(`DOR_OFS_SRC_HI, 0, 2'h0);
        wr(`DOR_OFS_HOST, 32'(host), 2'h0);
        outs(8'h00);
        cfg[10:8] = `DOR_SERMODE_HOST;
        wr(`DOR_OFS_CFG, cfg, 2'h0);
        outs(8'h00);
        inv = 8'hc3;
        wr(`DOR_OFS_INV, 32'(inv), 2'h0);
        ctrl <= 20'h00001;
        for (int q = 1; q < 3; q++) begin
            cfg[1:0] = 2'(q);
            wr(`DOR_OFS_CFG, cfg, 2'h0);
            outs(q == 1 ? 8'h03 : 8'hc0);
        end
        cfg = 32'h0000_0010;
        wr(`DOR_OFS_CFG, cfg, 2'h0);
        wr(`DOR_OFS_INV, 0, 2'h0);
        wr(`DOR_OFS_SRC_LO, 32'h1, 2'h0);
        ctrl <= 20'h0000c;
        repeat (2 * CYC + 5) @(posedge clk);
        chk("setpoint step", 0, 32'(dout[0]));
        cfg[14:12] = `DOR_CTYPE_CTRLUNIT;
        wr(`DOR_OFS_CFG, cfg, 2'h0);
        repeat (2 * CYC + 5) @(posedge clk);
        chk("setpoint step", 1, 32'(dout[0]));
        wr(`DOR_OFS_INV, 1, 2'h0);
        ctrl <= 20'h00000;
        repeat (2 * CYC + 5) @(posedge clk);
        chk("setpoint idle", 0, 32'(dout[0]));
        ana <= {12'h000, 12'habc, 12'h123, 12'h456};
        for (int s = 0; s < 5; s++) begin
            cfg[20:16] = (s == 4) ? 5'h11 : 5'(s);
            wr(`DOR_OFS_CFG, cfg, 2'h0);
            if (s == 4) ana <= {12'h000, 12'h000, 12'h123, 12'h456};
            repeat (2 * CYC + 5) @(posedge clk);
            chk("analog out", (s == 4) ? 32'(`DOR_AO_LIVE_ZERO) : 32'(ao_tab[s]), 32'(aout));
        end
        ana <= {12'h000, 12'hfff, 12'h123, 12'h456};
        repeat (2 * CYC + 5) @(posedge clk);
        rchk(`DOR_OFS_AOUT, 32'hfff, 32'hfff, 2'h0);
        clk_en <= 1'b0;
        ana <= '0;
        repeat (2 * CYC + 5) @(posedge clk);
        chk("frozen analog", 32'hfff, 32'(aout));
        clk_en <= 1'b1;
        wr(`DOR_OFS_IRQ_EN, 0, 2'h0);
        wr(`DOR_OFS_CFG, 32'h20, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", 0, 32'(irq));
        rchk(`DOR_OFS_IRQ_STAT, 4, 4, 2'h0);
        wr(`DOR_OFS_IRQ_EN, 4, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq raised", 1, 32'(irq));
        wr(`DOR_OFS_IRQ_CLR, 4, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq cleared", 0, 32'(irq));
        rchk(`DOR_OFS_IRQ_STAT, 0, 4, 2'h0);
        report_and_stop();
    end
endmodule : dor_top_test
